// >>> rtl/dfs_pkg.sv
// Behaviour
// - privileged access only, one copy per security state
// - bits 7:4 capture faulting domain number
// - bit 11 records read zero, write one
// - aborted coprocessor operation forces direction bit one
// - bit 12 shows decode or slave error
// - qualifier bit zero for non-external aborts
// - bit 10 is code bit 4, below the bit 12 qualifier
// - six-bit code from bits 12, 10, 3:0
// - highest priority class wins, alignment first
// - cache maintenance fault code 000100, second
// - walk external aborts x01100 and x01110
// - translation faults 000101 section, 000111 page
// - external aborts x01000 sync, x10110 async
// - reserved codes are never reported
// - qualifier resets to zero, decode error
// - reached by p15 c5 c0 opcode2 zero
// - reads return contents without side effect
// - writes load register for debugger restore
package dfs_pkg;
    // fault class request vector, index is priority (0 highest)
    localparam int unsigned NUM_CLASS = 15;
    localparam int unsigned CL_ALIGN      = 0;
    localparam int unsigned CL_ICMAINT    = 1;
    localparam int unsigned CL_WALK_L1    = 2;
    localparam int unsigned CL_WALK_L2    = 3;
    localparam int unsigned CL_TRANS_SEC  = 4;
    localparam int unsigned CL_TRANS_PAGE = 5;
    localparam int unsigned CL_AFLAG_SEC  = 6;
    localparam int unsigned CL_AFLAG_PAGE = 7;
    localparam int unsigned CL_DOM_SEC    = 8;
    localparam int unsigned CL_DOM_PAGE   = 9;
    localparam int unsigned CL_PERM_SEC   = 10;
    localparam int unsigned CL_PERM_PAGE  = 11;
    localparam int unsigned CL_SYNC_EXT   = 12;
    localparam int unsigned CL_ASYNC_EXT  = 13;
    localparam int unsigned CL_DEBUG      = 14;
    // low five code bits per class; bit 5 is the qualifier
    localparam logic [4:0] FC_ALIGN      = 5'h01;
    localparam logic [4:0] FC_ICMAINT    = 5'h04;
    localparam logic [4:0] FC_WALK_L1    = 5'h0c;
    localparam logic [4:0] FC_WALK_L2    = 5'h0e;
    localparam logic [4:0] FC_TRANS_SEC  = 5'h05;
    localparam logic [4:0] FC_TRANS_PAGE = 5'h07;
    localparam logic [4:0] FC_AFLAG_SEC  = 5'h03;
    localparam logic [4:0] FC_AFLAG_PAGE = 5'h06;
    localparam logic [4:0] FC_DOM_SEC    = 5'h09;
    localparam logic [4:0] FC_DOM_PAGE   = 5'h0b;
    localparam logic [4:0] FC_PERM_SEC   = 5'h0d;
    localparam logic [4:0] FC_PERM_PAGE  = 5'h0f;
    localparam logic [4:0] FC_SYNC_EXT   = 5'h08;
    localparam logic [4:0] FC_ASYNC_EXT  = 5'h16;
    localparam logic [4:0] FC_DEBUG      = 5'h02;
    // field positions in the register
    localparam int unsigned STATUS_LSB  = 0;
    localparam int unsigned DOMAIN_LSB  = 4;
    localparam int unsigned CODE_HI_BIT = 10;
    localparam int unsigned DIR_BIT     = 11;
    localparam int unsigned QUAL_BIT    = 12;
    // implemented bits mask, others read zero
    localparam logic [31:0] IMPL_MASK   = 32'h0000_1cff;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    // coprocessor selector for this register
    localparam logic [3:0] CP_NUM = 4'hf;
    localparam logic [3:0] CRN    = 4'h5;
    localparam logic [3:0] CRM    = 4'h0;
    localparam logic [2:0] OPC1   = 3'h0;
    localparam logic [2:0] OPC2   = 3'h0;
endpackage

// >>> rtl/dfs_fault_encode.sv
`timescale 1ns/1ps
`default_nettype none
// priority encoder: fault request vector to six-bit status code
module dfs_fault_encode (
    // fault requests, one bit per class
    input  wire logic [dfs_pkg::NUM_CLASS-1:0] class_req,
    input  wire logic                          bus_slverr,
    // encoded result
    output logic                               any_fault,
    output logic                               ext_class,
    output logic [5:0]                         code
);
    // table of low code bits indexed by class
    logic [4:0] tbl [dfs_pkg::NUM_CLASS];
    assign tbl[dfs_pkg::CL_ALIGN]      = dfs_pkg::FC_ALIGN;
    assign tbl[dfs_pkg::CL_ICMAINT]    = dfs_pkg::FC_ICMAINT;
    assign tbl[dfs_pkg::CL_WALK_L1]    = dfs_pkg::FC_WALK_L1;
    assign tbl[dfs_pkg::CL_WALK_L2]    = dfs_pkg::FC_WALK_L2;
    assign tbl[dfs_pkg::CL_TRANS_SEC]  = dfs_pkg::FC_TRANS_SEC;
    assign tbl[dfs_pkg::CL_TRANS_PAGE] = dfs_pkg::FC_TRANS_PAGE;
    assign tbl[dfs_pkg::CL_AFLAG_SEC]  = dfs_pkg::FC_AFLAG_SEC;
    assign tbl[dfs_pkg::CL_AFLAG_PAGE] = dfs_pkg::FC_AFLAG_PAGE;
    assign tbl[dfs_pkg::CL_DOM_SEC]    = dfs_pkg::FC_DOM_SEC;
    assign tbl[dfs_pkg::CL_DOM_PAGE]   = dfs_pkg::FC_DOM_PAGE;
    assign tbl[dfs_pkg::CL_PERM_SEC]   = dfs_pkg::FC_PERM_SEC;
    assign tbl[dfs_pkg::CL_PERM_PAGE]  = dfs_pkg::FC_PERM_PAGE;
    assign tbl[dfs_pkg::CL_SYNC_EXT]   = dfs_pkg::FC_SYNC_EXT;
    assign tbl[dfs_pkg::CL_ASYNC_EXT]  = dfs_pkg::FC_ASYNC_EXT;
    assign tbl[dfs_pkg::CL_DEBUG]      = dfs_pkg::FC_DEBUG;

    // lowest index wins; a table code comes out, or zero with no request
    always_comb begin
        int unsigned win;
        win       = 0;
        any_fault = 1'b0;
        for (int i = dfs_pkg::NUM_CLASS - 1; i >= 0; i--) begin
            if (class_req[i]) begin
                win       = i;
                any_fault = 1'b1;
            end
        end
        // external classes carry the bus response qualifier
        ext_class = any_fault &&
                    (win == dfs_pkg::CL_WALK_L1 ||
                     win == dfs_pkg::CL_WALK_L2 ||
                     win == dfs_pkg::CL_SYNC_EXT ||
                     win == dfs_pkg::CL_ASYNC_EXT);
        // qualifier held zero for all other classes
        code = any_fault ? {ext_class & bus_slverr, tbl[win]}
                         : 6'h00;
    end
endmodule
`default_nettype wire

// >>> rtl/dfs_bank_reg.sv
`timescale 1ns/1ps
`default_nettype none
// one banked copy of the status register
module dfs_bank_reg (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // load strobe and value
    input  wire logic        load,
    input  wire logic [31:0] load_val,
    // stored contents
    output logic [31:0]      value
);
    logic [31:0] val_q; // stored word
    logic [31:0] val_d; // next stored word

    // unimplemented bits are never stored so they read zero
    always_comb begin
        val_d = load ? (load_val & dfs_pkg::IMPL_MASK) : val_q;
    end

    // reset gives qualifier zero, decode error
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            val_q <= dfs_pkg::RESET_VALUE;
        end else begin
            val_q <= val_d;
        end
    end

    assign value = val_q;
endmodule
`default_nettype wire

// >>> rtl/dfs_capture.sv
`timescale 1ns/1ps
`default_nettype none
// data fault status capture, banked secure / non-secure
module dfs_capture (
    // clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          resetn,
    // fault report from load/store and translation logic
    input  wire logic                          abort_valid,
    input  wire logic [dfs_pkg::NUM_CLASS-1:0] abort_class,
    input  wire logic [3:0]                    abort_domain,
    input  wire logic                          abort_write,
    input  wire logic                          abort_cp_op,
    input  wire logic                          abort_slverr,
    input  wire logic                          abort_secure,
    // coprocessor transfer port
    input  wire logic                          cp_valid,
    input  wire logic                          cp_read,
    input  wire logic [3:0]                    cp_num,
    input  wire logic [2:0]                    cp_opc1,
    input  wire logic [3:0]                    cp_crn,
    input  wire logic [3:0]                    cp_crm,
    input  wire logic [2:0]                    cp_opc2,
    input  wire logic                          cp_privileged,
    input  wire logic                          cp_secure,
    input  wire logic [31:0]                   cp_wdata,
    // coprocessor answer
    output logic                               cp_ack,
    output logic                               cp_undef,
    output logic [31:0]                        cp_rdata,
    // captured status, one cycle after the abort
    output logic                               fault_captured,
    output logic [5:0]                         fault_code
);
    logic        any_fault; // a class was reported
    logic        ext_class; // winning class is external
    logic [5:0]  code;      // encoded status
    logic [31:0] fault_word;  // assembled capture value
    logic        hit;       // transfer selects this register
    logic        cp_ok;     // transfer allowed
    logic [1:0]  load;      // per bank load strobe
    logic [31:0] load_val [2];
    logic [31:0] bank_val [2];
    // answer registers
    logic        ack_q, ack_d;
    logic        undef_q, undef_d;
    logic [31:0] rdata_q, rdata_d;
    logic        cap_q, cap_d;
    logic [5:0]  code_q, code_d;

    dfs_fault_encode u_enc (
        .class_req (abort_class),
        .bus_slverr(abort_slverr),
        .any_fault (any_fault),
        .ext_class (ext_class),
        .code      (code)
    );

    // assemble the captured word from the code and access info
    always_comb begin
        fault_word = 32'h0000_0000;
        fault_word[dfs_pkg::STATUS_LSB +: 4] = code[3:0];
        fault_word[dfs_pkg::CODE_HI_BIT]     = code[4];
        fault_word[dfs_pkg::QUAL_BIT]        = code[5];
        fault_word[dfs_pkg::DOMAIN_LSB +: 4] = abort_domain;
        // cp operations always report a write
        fault_word[dfs_pkg::DIR_BIT] = abort_write | abort_cp_op;
    end

    // decode the p15 selector; user mode refused
    always_comb begin
        hit   = cp_valid && cp_num == dfs_pkg::CP_NUM &&
                cp_opc1 == dfs_pkg::OPC1 && cp_crn == dfs_pkg::CRN &&
                cp_crm == dfs_pkg::CRM && cp_opc2 == dfs_pkg::OPC2;
        cp_ok = hit && cp_privileged;
    end

    // per bank load: abort capture beats a write in the same cycle
    // so a fresh fault is never lost to a restore
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            load[b]     = 1'b0;
            load_val[b] = cp_wdata;
            if (any_fault && abort_valid &&
                abort_secure == (b == 1)) begin
                load[b]     = 1'b1;
                load_val[b] = fault_word;
            end else if (cp_ok && !cp_read &&
                         cp_secure == (b == 1)) begin
                load[b] = 1'b1;
            end
        end
    end

    // bank 0 non-secure, bank 1 secure
    for (genvar g = 0; g < 2; g++) begin : g_bank
        dfs_bank_reg u_bank (
            .core_clk(core_clk),
            .resetn  (resetn),
            .load    (load[g]),
            .load_val(load_val[g]),
            .value   (bank_val[g])
        );
    end

    // answer: ack for hit, undef for unprivileged, read data
    always_comb begin
        ack_d   = cp_ok;
        undef_d = hit && !cp_privileged;
        // reads have no side effect on the banks
        rdata_d = (cp_ok && cp_read) ? bank_val[cp_secure]
                                     : 32'h0000_0000;
        cap_d   = abort_valid && any_fault;
        code_d  = (abort_valid && any_fault) ? code : code_q;
    end

    // answer registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ack_q   <= 1'b0;
            undef_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            cap_q   <= 1'b0;
            code_q  <= 6'h00;
        end else begin
            ack_q   <= ack_d;
            undef_q <= undef_d;
            rdata_q <= rdata_d;
            cap_q   <= cap_d;
            code_q  <= code_d;
        end
    end

    assign cp_ack         = ack_q;
    assign cp_undef       = undef_q;
    assign cp_rdata       = rdata_q;
    assign fault_captured = cap_q;
    assign fault_code     = code_q;
endmodule
`default_nettype wire

// >>> bench/dfs_fault_src.sv
`timescale 1ns/1ps
`default_nettype none
// load/store and translation side: reports one abort per call
module dfs_fault_src (
    // clock
    input  wire logic                          core_clk,
    // abort report
    output logic                               abort_valid,
    output logic [dfs_pkg::NUM_CLASS-1:0]      abort_class,
    output logic [3:0]                         abort_domain,
    output logic                               abort_write,
    output logic                               abort_cp_op,
    output logic                               abort_slverr,
    output logic                               abort_secure
);
    // quiet at time zero
    initial begin
        abort_valid = 1'b0;
        {abort_class, abort_domain, abort_write} = '0;
        {abort_cp_op, abort_slverr, abort_secure} = '0;
    end

    // one-cycle report, then class, domain and slave error scrambled so stale data is not reused
    task automatic report(input logic [14:0] cls, input logic [3:0] dom,
                          input logic wr, cp, slv, sec);
        @(posedge core_clk);
        abort_valid  <= 1'b1;
        abort_class  <= cls;
        abort_domain <= dom;
        abort_write  <= wr;
        abort_cp_op  <= cp;
        abort_slverr <= slv;
        abort_secure <= sec;
        @(posedge core_clk);
        abort_valid  <= 1'b0;
        abort_class  <= ~cls;
        abort_domain <= ~dom;
        abort_slverr <= ~slv;
    endtask
endmodule
`default_nettype wire

// >>> bench/dfs_capture_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the status capture block
module dfs_capture_asserts (
    input  wire logic                          core_clk,
    input  wire logic                          resetn,
    input  wire logic                          abort_valid,
    input  wire logic [dfs_pkg::NUM_CLASS-1:0] abort_class,
    input  wire logic                          abort_slverr,
    input  wire logic                          cp_valid,
    input  wire logic [3:0]                    cp_num,
    input  wire logic [2:0]                    cp_opc1,
    input  wire logic [3:0]                    cp_crn,
    input  wire logic [3:0]                    cp_crm,
    input  wire logic [2:0]                    cp_opc2,
    input  wire logic                          cp_privileged,
    input  wire logic                          cp_ack,
    input  wire logic                          cp_undef,
    input  wire logic [31:0]                   cp_rdata,
    input  wire logic                          fault_captured,
    input  wire logic [5:0]                    fault_code
);
    // selector hit on this register only
    wire logic hit = cp_valid && cp_num == dfs_pkg::CP_NUM
        && cp_opc1 == dfs_pkg::OPC1 && cp_crn == dfs_pkg::CRN
        && cp_crm == dfs_pkg::CRM && cp_opc2 == dfs_pkg::OPC2;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_priv_ack: assert property (hit && cp_privileged |=> cp_ack && !cp_undef)
        else $error("privileged access not acknowledged");
    a_unpriv_undef: assert property (hit && !cp_privileged |=> cp_undef && !cp_ack)
        else $error("unprivileged access not refused");
    a_miss_silent: assert property (!hit |=> !cp_ack && !cp_undef)
        else $error("answer without a selector hit");
    a_rsvd_zero: assert property (cp_ack |-> (cp_rdata & ~dfs_pkg::IMPL_MASK) == 32'h0)
        else $error("reserved bits read nonzero");
    a_no_capture: assert property (!abort_valid |=> !fault_captured)
        else $error("capture without abort");
    a_align_first: assert property (abort_valid && abort_class[0] |=> fault_captured && fault_code == 6'h01)
        else $error("alignment not reported first");
    a_icm_second: assert property (abort_valid && abort_class[1:0] == 2'b10 |=> fault_code == 6'h04)
        else $error("cache maintenance not second");
    a_qual_zero: assert property (fault_captured && !(fault_code[4:0] inside {5'h0c, 5'h0e, 5'h08, 5'h16}) |-> !fault_code[5])
        else $error("qualifier set on non-external abort");
    a_code_legal: assert property (fault_captured |-> fault_code[4:0] inside {5'h01, 5'h04, 5'h0c, 5'h0e, 5'h05, 5'h07, 5'h03, 5'h06, 5'h09, 5'h0b, 5'h0d, 5'h0f, 5'h08, 5'h16, 5'h02})
        else $error("reserved code reported");
    a_sync_ext: assert property (abort_valid && abort_class == 15'h1000 |=> fault_code == {$past(abort_slverr), 5'h08})
        else $error("sync external code wrong");

    // main scenarios reached
    c_undef: cover property (hit && !cp_privileged);
    c_prio: cover property (abort_valid && abort_class[0] && abort_class[14]);
    c_slverr: cover property (abort_valid && abort_class[12] && abort_slverr);
endmodule
bind dfs_capture dfs_capture_asserts i_chk (.*);
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                          core_clk, resetn;
    logic                          abort_valid, abort_write, abort_cp_op;
    logic                          abort_slverr, abort_secure;
    logic [dfs_pkg::NUM_CLASS-1:0] abort_class;
    logic [3:0]                    abort_domain, cp_num, cp_crn, cp_crm;
    logic                          cp_valid, cp_read, cp_privileged, cp_secure;
    logic [2:0]                    cp_opc1, cp_opc2;
    logic [31:0]                   cp_wdata, cp_rdata, rd_q;
    logic                          cp_ack, cp_undef, fault_captured;
    logic [5:0]                    fault_code;
    logic [1:0]                    ans;
    int                            failures, checks_done;
    // low five code bits per class, priority order
    logic [4:0] fc_tab [15] = '{5'h01, 5'h04, 5'h0c, 5'h0e, 5'h05, 5'h07,
        5'h03, 5'h06, 5'h09, 5'h0b, 5'h0d, 5'h0f, 5'h08, 5'h16, 5'h02};

    dfs_capture i_dut (.*);
    dfs_fault_src i_src (.*);

    always #5 core_clk = ~core_clk;

    // expected register word from its fields
    function automatic logic [31:0] ew(input logic q, d, input logic [4:0] c,
                                       input logic [3:0] dm);
        return {19'h0, q, d, c[4], 2'b00, dm, c[3:0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one transfer; selector fixed except second opcode
    task automatic cp_xfer(input logic rd, pv, sec, input logic [2:0] o2,
                           input logic [31:0] wd);
        @(posedge core_clk);
        cp_valid      <= 1'b1;
        cp_read       <= rd;
        cp_privileged <= pv;
        cp_secure     <= sec;
        cp_opc2       <= o2;
        cp_wdata      <= wd;
        @(posedge core_clk);
        cp_valid <= 1'b0;
        cp_wdata <= ~wd;
        #1;
        ans  = {cp_undef, cp_ack};
        rd_q = cp_rdata;
    endtask

    task automatic rd_chk(input logic sec, input logic [31:0] e);
        cp_xfer(1'b1, 1'b1, sec, 3'h0, 32'h0);
        chk("read ack", 32'h1, {30'h0, ans});
        chk("read data", e, rd_q);
    endtask

    task automatic ab(input logic [14:0] cls, input logic [3:0] dm,
                      input logic wr, cp, slv, sec, input logic [31:0] e);
        i_src.report(cls, dm, wr, cp, slv, sec);
        #1;
        chk("captured", 32'h1, {31'h0, fault_captured});
        chk("fault code", {26'h0, e[12], e[10], e[3:0]}, {26'h0, fault_code});
        rd_chk(sec, e);
    endtask

    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // watchdog, far beyond the roughly 105 cycles needed
    initial begin
        repeat (3000) @(posedge core_clk);
        failures++;
        final_report;
    end

    initial begin
        core_clk = 1'b0;
        resetn   = 1'b0;
        {cp_valid, cp_read, cp_privileged, cp_secure, cp_wdata} = '0;
        {cp_num, cp_opc1, cp_crn, cp_crm, cp_opc2} = {4'hf, 3'h0, 4'h5, 4'h0, 3'h0};
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        rd_chk(1'b0, 32'h0);
        rd_chk(1'b1, 32'h0);
        ab(15'h1000, 4'h3, 0, 0, 1, 0, 32'h0000_1038);
        for (int i = 0; i < 15; i++)
            ab(15'h1 << i, i[3:0], 1, 0, 1, 1, ew(i inside {2, 3, 12, 13}, 1, fc_tab[i], i[3:0]));
        ab(15'h4001, 4'ha, 0, 0, 1, 0, ew(0, 0, 5'h01, 4'ha));
        ab(15'h7ffe, 4'h5, 0, 1, 0, 0, ew(0, 1, 5'h04, 4'h5));
        ab(15'h2000, 4'hf, 0, 0, 0, 0, ew(0, 0, 5'h16, 4'hf));
        // a report with no class bit set must leave the bank alone
        i_src.report(15'h0, 4'h1, 1, 0, 1, 0);
        #1;
        chk("empty report", 32'h0, {31'h0, fault_captured});
        rd_chk(1'b0, ew(0, 0, 5'h16, 4'hf));
        cp_xfer(1'b0, 1'b1, 1'b0, 3'h0, 32'hffff_ffff);
        chk("write ack", 32'h1, {30'h0, ans});
        rd_chk(1'b0, 32'h0000_1cff);
        rd_chk(1'b1, ew(0, 1, 5'h02, 4'he));
        cp_xfer(1'b0, 1'b0, 1'b0, 3'h0, 32'h0);
        chk("unpriv undef", 32'h2, {30'h0, ans});
        cp_xfer(1'b1, 1'b1, 1'b0, 3'h1, 32'h0);
        chk("miss silent", 32'h0, {30'h0, ans});
        rd_chk(1'b0, 32'h0000_1cff);
        cp_xfer(1'b0, 1'b1, 1'b0, 3'h0, (rd_q & ~32'hf0) | 32'h50);
        rd_chk(1'b0, 32'h0000_1c5f);
        final_report;
    end
endmodule
`default_nettype wire
